// File: sdr_regmap.sv
// serial-port register bank with shadowed, per-channel program registers
//
// Function
// - After power-on or soft reset every configuration register takes its default value.
// - Writes to 0x08..0x18 change only the shadow copy, not live operation.
// - Writing 0x01 to 0xFF sets the commit bit that triggers the shadow transfer.
// - Setting the commit bit copies all shadow registers into the live copies at once.
// - The commit bit clears itself right after the copy.
// - Local registers exist once per channel.
// - Register 0x05 bit 0 steers access to channel A, bit 1 to channel B.
// - With both select bits set a local write updates both channels alike.
// - With both select bits set a local read returns channel A.
// - Global registers are written to both channels alike and ignore the channel select.
// - The grade register shows the speed code in bits 6 to 4.
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"

module sdr_regmap import sdr_pkg::*; #(
  parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
  parameter logic [2:0] SPEED_GRADE = 3'h3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csbN,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output sdr_bank_t activeA,
  output sdr_bank_t activeB,
  output logic lsbFirst
);

  sdr_top_s st_q;
  sdr_top_s st_d;

  logic sclkRise;
  logic sclkFall;
  logic [15:0] instrNext;
  logic [7:0] byteNext;
  logic byteDone;
  logic [7:0] readValue;
  logic [7:0] bankRdData;
  logic inBank;
  logic [4:0] bankIdx;
  logic isGlobal;
  logic [1:0] bankWrChan;
  logic bankRdChan;
  logic commit;
  logic [12:0] addrNext;
  logic lastByte;
  logic [16:0] globalMask;
  logic [7:0] readRev;

  // edges of the synchronised serial clock
  assign sclkRise = st_q.sclkSync & ~st_q.sclkPrev;
  assign sclkFall = ~st_q.sclkSync & st_q.sclkPrev;

  // incoming bit lands at the top or the bottom by bit order
  always_comb begin
    if (st_q.lsbFirst) begin
      instrNext = {st_q.sdioSync, st_q.instr[15:1]};
      byteNext = {st_q.sdioSync, st_q.rxByte[7:1]};
    end else begin
      instrNext = {st_q.instr[14:0], st_q.sdioSync};
      byteNext = {st_q.rxByte[6:0], st_q.sdioSync};
    end
  end

  // address decode of the shadow range
  assign inBank = (st_q.addr >= `SDR_ADDR_BANK_LO) && (st_q.addr <= `SDR_ADDR_BANK_HI);
  assign bankIdx = 5'(st_q.addr - `SDR_ADDR_BANK_LO);
  assign globalMask = `SDR_GLOBAL_MASK;
  assign isGlobal = inBank && globalMask[bankIdx];

  // bit-reversed read value for LSB-first replies
  for (genvar b = 0; b < 8; b++) begin : g_rev
    assign readRev[b] = readValue[7 - b];
  end

  // address walks down, or up in LSB-first mode
  assign addrNext = st_q.lsbFirst ? (st_q.addr + 13'h0001) : (st_q.addr - 13'h0001);
  assign byteDone = sclkRise && (st_q.bitCnt[2:0] == `SDR_BYTE_LAST);
  assign lastByte = !st_q.stream && (st_q.byteCnt == 2'h0);

  // channel steering for the shadow memory
  always_comb begin
    if (isGlobal) begin
      bankWrChan = 2'h3;
      bankRdChan = 1'b0;
    end else begin
      bankWrChan = st_q.chanSel;
      bankRdChan = (st_q.chanSel == 2'h2);
    end
    if (!(st_q.state == SDR_WRITE && byteDone && inBank)) begin
      bankWrChan = 2'h0;
    end
  end

  // read data of the addressed register
  always_comb begin
    case (st_q.addr)
      `SDR_ADDR_CONFIG: begin
        readValue = `SDR_RST_CONFIG;
        readValue[`SDR_CFG_LSB_HI] = st_q.lsbFirst;
        readValue[`SDR_CFG_LSB_LO] = st_q.lsbFirst;
      end
      `SDR_ADDR_IDENT: readValue = DEVICE_ID;
      `SDR_ADDR_GRADE: readValue = {1'b0, SPEED_GRADE, 4'h0};
      `SDR_ADDR_CHSEL: readValue = {6'h00, st_q.chanSel};
      `SDR_ADDR_COMMIT: readValue = {7'h00, st_q.commitBit};
      default: readValue = inBank ? bankRdData : 8'h00;
    endcase
  end

  // commit runs in the same cycle that the bit is set
  assign commit = st_q.commitBit;

  // frame engine, register writes and control bits
  always_comb begin
    st_d = st_q;
    st_d.csbMeta = csbN;
    st_d.csbSync = st_q.csbMeta;
    st_d.sclkMeta = sclk;
    st_d.sclkSync = st_q.sclkMeta;
    st_d.sclkPrev = st_q.sclkSync;
    st_d.sdioMeta = sdioIn;
    st_d.sdioSync = st_q.sdioMeta;
    st_d.softRst = 1'b0;
    st_d.commitBit = 1'b0;
    case (st_q.state)
      SDR_IDLE: begin
        st_d.bitCnt = 4'h0;
        st_d.driveOut = 1'b0;
        if (!st_q.csbSync) begin
          st_d.state = SDR_INSTR;
        end
      end
      SDR_INSTR: begin
        if (sclkRise) begin
          st_d.instr = instrNext;
          st_d.bitCnt = st_q.bitCnt + 4'h1;
          if (st_q.bitCnt == `SDR_INSTR_LAST) begin
            st_d.bitCnt = 4'h0;
            st_d.addr = instrNext[12:0];
            st_d.byteCnt = instrNext[`SDR_INSTR_LEN_HI:`SDR_INSTR_LEN_LO];
            st_d.stream = (instrNext[`SDR_INSTR_LEN_HI:`SDR_INSTR_LEN_LO] == `SDR_LEN_STREAM);
            st_d.state = instrNext[`SDR_INSTR_RW] ? SDR_READ : SDR_WRITE;
          end
        end
      end
      SDR_WRITE: begin
        if (sclkRise) begin
          st_d.rxByte = byteNext;
          st_d.bitCnt = {1'b0, st_q.bitCnt[2:0] + 3'h1};
        end
        if (byteDone) begin
          case (st_q.addr)
            `SDR_ADDR_CONFIG: begin
              st_d.lsbFirst = byteNext[`SDR_CFG_LSB_HI] | byteNext[`SDR_CFG_LSB_LO];
              st_d.softRst = byteNext[`SDR_CFG_SRST_HI] | byteNext[`SDR_CFG_SRST_LO];
            end
            `SDR_ADDR_CHSEL: st_d.chanSel = byteNext[1:0];
            `SDR_ADDR_COMMIT: st_d.commitBit = byteNext[`SDR_COMMIT_BIT];
            default: st_d.commitBit = 1'b0; // identity, grade and open locations ignore writes
          endcase
          st_d.addr = addrNext;
          st_d.byteCnt = st_q.byteCnt - 2'h1;
          if (lastByte) begin
            st_d.state = SDR_HOLD;
          end
        end
      end
      SDR_READ: begin
        if (sclkFall) begin
          st_d.driveOut = 1'b1;
          if (st_q.bitCnt[2:0] == 3'h0) begin
            st_d.txShift = st_q.lsbFirst ? readRev : readValue;
          end else begin
            st_d.txShift = {st_q.txShift[6:0], 1'b0};
          end
        end
        if (sclkRise) begin
          st_d.bitCnt = {1'b0, st_q.bitCnt[2:0] + 3'h1};
        end
        if (byteDone) begin
          st_d.addr = addrNext;
          st_d.byteCnt = st_q.byteCnt - 2'h1;
          if (lastByte) begin
            st_d.state = SDR_HOLD;
          end
        end
      end
      SDR_HOLD: begin
        if (sclkFall) begin
          st_d.driveOut = 1'b0;
        end
      end
      default: begin
        st_d.state = SDR_IDLE;
      end
    endcase
    // chip select high ends any frame at once
    if (st_q.csbSync) begin
      st_d.state = SDR_IDLE;
      st_d.driveOut = 1'b0;
    end
    // a commit written in the same cycle wins over the self-clear
    if (st_q.state == SDR_WRITE && byteDone && st_q.addr == `SDR_ADDR_COMMIT) begin
      st_d.commitBit = byteNext[`SDR_COMMIT_BIT];
    end
    // soft reset brings the control bits back to their defaults
    if (st_q.softRst) begin
      st_d.lsbFirst = 1'b0;
      st_d.chanSel = `SDR_RST_CHSEL;
      st_d.commitBit = 1'b0;
    end
  end

  // state register with power-on defaults
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.csbMeta <= 1'b1;
      st_q.csbSync <= 1'b1;
      st_q.state <= SDR_IDLE;
      st_q.chanSel <= `SDR_RST_CHSEL;
    end else begin
      st_q <= st_d;
    end
  end

  // shadow and live copies of the program registers
  sdr_shadow_bank u_bank (
    .clock(clock),
    .resetn(resetn),
    .loadDefaults(st_q.softRst),
    .wrChan(bankWrChan),
    .wrIdx(bankIdx),
    .wrData(byteNext),
    .rdIdx(bankIdx),
    .rdChan(bankRdChan),
    .commit(commit),
    .rdData(bankRdData),
    .activeA(activeA),
    .activeB(activeB)
  );

  // serial data out and pin direction
  assign sdioOut = st_q.txShift[7];
  assign sdioOe = st_q.driveOut;
  assign lsbFirst = st_q.lsbFirst;

endmodule // sdr_regmap

`default_nettype wire

// File: sdr_map.svh
// offsets, field positions, reset values and frame constants of the register bank
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH

// register offsets
`define SDR_ADDR_CONFIG 13'h0000
`define SDR_ADDR_IDENT 13'h0001
`define SDR_ADDR_GRADE 13'h0002
`define SDR_ADDR_CHSEL 13'h0005
`define SDR_ADDR_COMMIT 13'h00FF
`define SDR_ADDR_BANK_LO 13'h0008
`define SDR_ADDR_BANK_HI 13'h0018

// shadow bank geometry and global entries (0x09 and 0x0B)
`define SDR_BANK_N 17
`define SDR_BANK_W 5
`define SDR_GLOBAL_MASK 17'h0000A

// reset values
`define SDR_RST_CONFIG 8'h18
`define SDR_RST_CHSEL 2'h3
`define SDR_RST_BANK0 8'h80

// field positions in the configuration, commit and grade registers
`define SDR_CFG_LSB_HI 6
`define SDR_CFG_LSB_LO 1
`define SDR_CFG_SRST_HI 5
`define SDR_CFG_SRST_LO 2
`define SDR_COMMIT_BIT 0
`define SDR_GRADE_LSB 4

// instruction layout
`define SDR_INSTR_RW 15
`define SDR_INSTR_LEN_HI 14
`define SDR_INSTR_LEN_LO 13
`define SDR_INSTR_LAST 4'hF
`define SDR_BYTE_LAST 3'h7
`define SDR_LEN_STREAM 2'h3

`endif

// File: sdr_pkg.sv
// types shared by the register bank and its shadow memory
`default_nettype none
package sdr_pkg;

  // serial frame states, one-hot
  typedef enum logic [4:0] {
    SDR_IDLE = 5'b00001,
    SDR_INSTR = 5'b00010,
    SDR_WRITE = 5'b00100,
    SDR_READ = 5'b01000,
    SDR_HOLD = 5'b10000
  } sdr_state_e;

  typedef logic [16:0][7:0] sdr_bank_t;

  // state of the shadow memory
  typedef struct packed {
    logic [1:0][16:0][7:0] shadow;
    logic [1:0][16:0][7:0] active;
    logic [7:0] rdData;
  } sdr_bank_s;

  // state of the serial register front end
  typedef struct packed {
    logic csbMeta;
    logic csbSync;
    logic sclkMeta;
    logic sclkSync;
    logic sclkPrev;
    logic sdioMeta;
    logic sdioSync;
    sdr_state_e state;
    logic [15:0] instr;
    logic [3:0] bitCnt;
    logic [1:0] byteCnt;
    logic stream;
    logic [12:0] addr;
    logic [7:0] rxByte;
    logic [7:0] txShift;
    logic driveOut;
    logic lsbFirst;
    logic [1:0] chanSel;
    logic commitBit;
    logic softRst;
  } sdr_top_s;

endpackage
`default_nettype wire

// File: sdr_shadow_bank.sv
// shadow and active copies of the program registers for both channels
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"

module sdr_shadow_bank import sdr_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic loadDefaults,
  input wire logic [1:0] wrChan,
  input wire logic [4:0] wrIdx,
  input wire logic [7:0] wrData,
  input wire logic [4:0] rdIdx,
  input wire logic rdChan,
  input wire logic commit,
  output logic [7:0] rdData,
  output sdr_bank_t activeA,
  output sdr_bank_t activeB
);

  sdr_bank_s st_q;
  sdr_bank_s st_d;

  // per-channel shadow writes, defaults and commit copy
  always_comb begin
    st_d = st_q;
    for (int ch = 0; ch < 2; ch++) begin
      if (wrChan[ch] && (wrIdx < 5'(`SDR_BANK_N))) begin
        st_d.shadow[ch][wrIdx] = wrData;
      end
      if (commit) begin
        st_d.active[ch] = st_q.shadow[ch];
      end
      if (loadDefaults) begin
        st_d.shadow[ch] = '0;
        st_d.shadow[ch][0] = `SDR_RST_BANK0;
        st_d.active[ch] = '0;
        st_d.active[ch][0] = `SDR_RST_BANK0;
      end
    end
    st_d.rdData = (rdIdx < 5'(`SDR_BANK_N)) ? st_q.shadow[rdChan][rdIdx] : 8'h00;
  end

  // state register, defaults at reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.shadow[0][0] <= `SDR_RST_BANK0;
      st_q.shadow[1][0] <= `SDR_RST_BANK0;
      st_q.active[0][0] <= `SDR_RST_BANK0;
      st_q.active[1][0] <= `SDR_RST_BANK0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign activeA = st_q.active[0];
  assign activeB = st_q.active[1];

endmodule // sdr_shadow_bank

`default_nettype wire

// File: sdr_regmap_properties.sv
// port-level assertions and covers of the register bank
`timescale 1ns/1ns
`default_nettype none

module sdr_regmap_properties import sdr_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csbN,
  input wire logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire sdr_bank_t activeA,
  input wire sdr_bank_t activeB,
  input wire logic lsbFirst
);
  // single domain, reset masks all but the reset check
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // reset values, live updates only inside frames
  property p_rstVals;
    disable iff (1'b0) !resetn |-> activeA == 136'h80 && activeB == 136'h80 && !lsbFirst && !sdioOe;
  endproperty
  property p_globalTwin;
    activeA[1] == activeB[1] && activeA[3] == activeB[3];
  endproperty
  property p_liveAQuiet;
    $changed(activeA) |-> !$past(csbN);
  endproperty
  property p_liveBQuiet;
    $changed(activeB) |-> !$past(csbN);
  endproperty
  property p_oneUpdate;
    $changed(activeA) |=> $stable(activeA) [*4];
  endproperty
  property p_orderQuiet;
    $changed(lsbFirst) |-> !$past(csbN);
  endproperty
  property p_oeIdle;
    csbN [*4] |-> !sdioOe;
  endproperty
  property p_shiftOnLow;
    sdioOe && $past(sdioOe) && $changed(sdioOut) |-> !$past(sclk);
  endproperty

  a_rstVals: assert property (p_rstVals) else $error("bad reset values");
  a_globalTwin: assert property (p_globalTwin) else $error("globals differ");
  a_liveAQuiet: assert property (p_liveAQuiet) else $error("live A moved idle");
  a_liveBQuiet: assert property (p_liveBQuiet) else $error("live B moved idle");
  a_oneUpdate: assert property (p_oneUpdate) else $error("split live update");
  a_orderQuiet: assert property (p_orderQuiet) else $error("order moved idle");
  a_oeIdle: assert property (p_oeIdle) else $error("drives while deselected");
  a_shiftOnLow: assert property (p_shiftOnLow) else $error("shift with clock high");

  // main scenarios reached
  c_update: cover property ($changed(activeA));
  c_read: cover property ($rose(sdioOe));
  c_lsb: cover property ($rose(lsbFirst));
endmodule // sdr_regmap_properties

bind sdr_regmap sdr_regmap_properties i_sdr_regmap_properties (.clock(clock), .resetn(resetn),
  .sclk(sclk), .csbN(csbN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
  .activeA(activeA), .activeB(activeB), .lsbFirst(lsbFirst));
`default_nettype wire

// File: sdr_host_model.sv
// serial host controller model driving the three-wire port
`timescale 1ns/1ns
`default_nettype none

module sdr_host_model (
  input wire logic clock,
  input wire logic sdioOut,
  input wire logic sdioOe,
  output logic sclk,
  output logic csbN,
  output logic sdioIn
);
  logic dq = 1'b0;
  logic [7:0] lastRd = 8'h00;
  event done;
  initial sclk = 1'b0;
  initial csbN = 1'b1;
  // wire level from the device enable: device output while sdioOe is high, host bit otherwise
  assign sdioIn = sdioOe ? sdioOut : dq;

  // one frame: instruction, one or two data bytes; clock stands still outside
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, input logic lsb,
    output logic [7:0] rd);
    int i;
    int nBits;
    logic [3:0] j;
    rd = 8'h00;
    nBits = (ins[14:13] == 2'b01) ? 32 : 24;
    @(negedge clock) csbN = 1'b0;
    for (i = 0; i < nBits; i++) begin
      j = 4'(i - 16);
      if (i < 16) dq = lsb ? ins[i] : ins[15 - i];
      else if (ins[15]) dq = ~dq; // released line keeps toggling
      else dq = wd[{j[3], lsb ? j[2:0] : ~j[2:0]}];
      repeat (5) @(negedge clock);
      sclk = 1'b1;
      if (i >= 16 && i < 24) rd[lsb ? j[2:0] : ~j[2:0]] = sdioIn;
      repeat (5) @(negedge clock);
      sclk = 1'b0;
    end
    lastRd = rd;
    if (ins[15]) -> done;
    repeat (5) @(negedge clock);
    csbN = 1'b1;
    repeat (5) @(negedge clock);
  endtask
endmodule // sdr_host_model
`default_nettype wire

// File: sdr_regmap_tb.sv
// self-checking bench of the register bank
`timescale 1ns/1ns
`default_nettype none
`include "sdr_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module sdr_regmap_tb import sdr_pkg::*;;
  localparam logic [7:0] ID = 8'hC3; // arbitrary value
  localparam logic [2:0] GRADE = 3'h2;
  logic clock = 1'b0;
  logic resetn = 1'b1;
  logic lsbMode = 1'b0;
  logic sclk, csbN, sdioIn, sdioOut, sdioOe, lsbFirst;
  sdr_bank_t activeA, activeB;
  logic [31:0] seed = 32'hACB6FA69;
  logic [7:0] expQ[$];
  logic [7:0] r1, r2, r3, r4;
  int badCount = 0;
  int checked = 0;

  sdr_regmap #(.DEVICE_ID(ID), .SPEED_GRADE(GRADE)) i_sdr_regmap (.clock(clock),
    .resetn(resetn), .sclk(sclk), .csbN(csbN), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .activeA(activeA), .activeB(activeB), .lsbFirst(lsbFirst));
  sdr_host_model i_sdr_host_model (.clock(clock), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .sclk(sclk), .csbN(csbN), .sdioIn(sdioIn));

  // 40 ns clock
  initial begin
    forever #20 clock = ~clock;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic conclude();
    if (expQ.size() != 0) badCount++;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // register writes and reads over the serial host
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_sdr_host_model.xfer({3'b000, a}, {8'h00, d}, lsbMode, r);
  endtask
  task automatic wr2(input logic [12:0] a, input logic [15:0] d);
    logic [7:0] r;
    i_sdr_host_model.xfer({3'b001, a}, d, lsbMode, r);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    expQ.push_back(e);
    i_sdr_host_model.xfer({3'b100, a}, 16'h0000, lsbMode, r);
  endtask

  // watcher takes the oldest note per returned byte
  initial begin
    forever begin
      @(i_sdr_host_model.done);
      if (expQ.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(i_sdr_host_model.lastRd, expQ.pop_front())
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    conclude();
  end

  // main sequence
  initial begin
    #1 resetn = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    rd(`SDR_ADDR_CONFIG, 8'h18);
    rd(`SDR_ADDR_CHSEL, 8'h03);
    `CHK(activeA[0], 8'h80)
    rd(`SDR_ADDR_IDENT, ID);
    wr(`SDR_ADDR_IDENT, ~ID);
    rd(`SDR_ADDR_IDENT, ID);
    rd(`SDR_ADDR_GRADE, {1'b0, GRADE, 4'h0});
    r1 = rnd();
    r2 = rnd();
    r3 = rnd();
    r4 = rnd();
    wr(`SDR_ADDR_CHSEL, 8'h01);
    wr(13'h000A, r1);
    wr(`SDR_ADDR_CHSEL, 8'h02);
    wr(13'h000A, r2);
    `CHK(activeA[2], 8'h00)
    `CHK(activeB[2], 8'h00)
    rd(13'h000A, r2);
    wr(`SDR_ADDR_CHSEL, 8'h01);
    rd(13'h000A, r1);
    wr(13'h0009, r4);
    wr(`SDR_ADDR_CHSEL, 8'h03);
    rd(13'h000A, r1);
    wr(13'h000C, r3);
    wr(`SDR_ADDR_COMMIT, 8'h01);
    rd(`SDR_ADDR_COMMIT, 8'h00);
    `CHK({activeA[2], activeB[2]}, {r1, r2})
    `CHK({activeA[4], activeB[4]}, {r3, r3})
    `CHK(activeB[1], r4)
    wr(`SDR_ADDR_CHSEL, 8'h02);
    rd(13'h0009, r4);
    wr2(13'h000D, {r2, r1});
    rd(13'h000C, r2);
    rd(13'h000D, r1);
    wr(13'h0003, rnd());
    rd(13'h0003, 8'h00);
    wr(`SDR_ADDR_CONFIG, 8'h42);
    `CHK(lsbFirst, 1'b1)
    lsbMode = 1'b1;
    rd(`SDR_ADDR_CONFIG, 8'h5A);
    rd(`SDR_ADDR_GRADE, {1'b0, GRADE, 4'h0});
    wr(13'h000A, r3);
    rd(13'h000A, r3);
    wr(`SDR_ADDR_CONFIG, 8'h24);
    lsbMode = 1'b0;
    `CHK(lsbFirst, 1'b0)
    `CHK({activeA[0], activeA[2], activeB[1]}, {8'h80, 8'h00, 8'h00})
    rd(`SDR_ADDR_CHSEL, 8'h03);
    conclude();
  end
endmodule // sdr_regmap_tb
`default_nettype wire
